// ==== hdl/hsr_defs.svh ====
// Purpose: constants for the high-speed input request unit
// Assumes: 20 MHz clock, APB register access, one aligned word per register
// Notes:   offsets are byte addresses; times are kept in their own unit
`ifndef HSR_DEFS_SVH
`define HSR_DEFS_SVH

// Register offsets
`define HSR_OFS_CTRL        12'h000
`define HSR_OFS_VALID       12'h004
`define HSR_OFS_STATUS      12'h008
`define HSR_OFS_INT_STAT    12'h00C
`define HSR_OFS_INT_MASK    12'h010
`define HSR_OFS_TSTAMP      12'h014
`define HSR_ENTRY_REGION    3'h2
`define HSR_ENT_CFG         2'h0
`define HSR_ENT_COMP        2'h1
`define HSR_ENT_TIME        2'h2

// Entry configuration fields
`define HSR_CFG_SRC_LSB     0
`define HSR_CFG_SRC_MSB     1
`define HSR_CFG_CH_LSB      2
`define HSR_CFG_CH_MSB      6
`define HSR_CFG_FALLING     7
`define HSR_CFG_VALID_USED  8
`define HSR_CFG_ACT_LSB     9
`define HSR_CFG_ACT_MSB     11
`define HSR_CFG_ENABLE      12
`define HSR_CFG_WIDTH       13

// Reset values
`define HSR_RST_CFG         13'h0000
`define HSR_RST_WORD        32'h0000_0000
`define HSR_RST_RESP        2'h0

// Compensation limits, +/-5000000 us
`define HSR_COMP_MAX_US     32'sh004C_4B40
`define HSR_COMP_MIN_US     32'shFFB3_B4C0

// Timing
`define HSR_CLK_PERIOD_NS   50
`define HSR_US_NS           1000
`define HSR_CYC_PER_US      ((`HSR_US_NS) / (`HSR_CLK_PERIOD_NS))
`define HSR_ACC_BI_US       30
`define HSR_ACC_R04_US      69
`define HSR_ACC_R06_US      133
`define HSR_ACC_R10_US      261
`define HSR_ACC_BI_CYC      (`HSR_ACC_BI_US * `HSR_CYC_PER_US)
`define HSR_ACC_R04_CYC     (`HSR_ACC_R04_US * `HSR_CYC_PER_US)
`define HSR_ACC_R06_CYC     (`HSR_ACC_R06_US * `HSR_CYC_PER_US)
`define HSR_ACC_R10_CYC     (`HSR_ACC_R10_US * `HSR_CYC_PER_US)

`endif

// ==== hdl/hsr_pkg.sv ====
// Purpose: types of the high-speed input request unit
// Assumes: constants live in hsr_defs.svh
// Notes:   none
package hsr_pkg;

   typedef enum logic [1:0] {
      HSR_SRC_BUILTIN = 2'b00,
      HSR_SRC_PROX    = 2'b01,
      HSR_SRC_TRACK   = 2'b10,
      HSR_SRC_NONE    = 2'b11
   } hsr_src_t;

   typedef enum logic [2:0] {
      HSR_ACT_CLUTCH_ON  = 3'b000,
      HSR_ACT_CLUTCH_OFF = 3'b001,
      HSR_ACT_CNT_ENABLE = 3'b010,
      HSR_ACT_CNT_DISABLE = 3'b011,
      HSR_ACT_VALUE_CHG  = 3'b100
   } hsr_action_t;

   typedef enum logic [1:0] {
      HSR_RESP_0P4 = 2'b00,
      HSR_RESP_0P6 = 2'b01,
      HSR_RESP_1P0 = 2'b10
   } hsr_resp_t;

   typedef logic [2:0][31:0] hsr_chan_t;

endpackage : hsr_pkg

// ==== hdl/hsr_request_unit.sv ====
// Purpose: edge capture, compensation and validation of high-speed input requests
// Assumes: inputs synchronous to clock_i; op_cycle_i is a one-cycle pulse per operation cycle
// Notes:   zero-wait APB slave; edges are detected on a per-source sampling grid
//
// Local design decisions: the placing of the registers and register access over APB.
`include "hsr_defs.svh"

module hsr_request_unit
   import hsr_pkg::*;
#(
   parameter int NENT        = 32,
   parameter int NDI         = 4,
   parameter int NPROX       = 8,
   parameter int NTREN       = 8,
   parameter int ACC_BI_CYC  = `HSR_ACC_BI_CYC,
   parameter int ACC_R04_CYC = `HSR_ACC_R04_CYC,
   parameter int ACC_R06_CYC = `HSR_ACC_R06_CYC,
   parameter int ACC_R10_CYC = `HSR_ACC_R10_CYC,
   parameter int CYC_PER_US  = `HSR_CYC_PER_US
) (
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   // APB slave
   input  wire logic [11:0]       paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Request sources
   input  wire logic [NDI-1:0]    builtin_digital_input_i,
   input  wire logic [NPROX-1:0]  proximity_change_input_i,
   input  wire logic [NTREN-1:0]  tracking_enable_input_i,
   input  wire logic              ext_main_base_i,
   // Synchronous control side
   input  wire logic              op_cycle_i,
   input  wire logic [NENT-1:0]   sync_control_active_i,
   input  wire logic [NENT-1:0]   encoder_axis_control_request_i,
   // Events
   output logic      [NENT-1:0]   event_o,
   output logic                   event_strobe_o,
   output logic      [4:0]        event_entry_o,
   output logic      [2:0]        event_action_o,
   output logic      [31:0]       event_time_o,
   output logic                   irq_o
);

   // Saturate a signed compensation to the legal window
   function automatic logic [31:0] sat_comp(input logic [31:0] v);
      if ($signed(v) > $signed(`HSR_COMP_MAX_US)) begin
         sat_comp = `HSR_COMP_MAX_US;
      end else if ($signed(v) < $signed(`HSR_COMP_MIN_US)) begin
         sat_comp = `HSR_COMP_MIN_US;
      end else begin
         sat_comp = v;
      end
   endfunction

   // Pick one channel bit of a source class; no source reads as low
   function automatic logic src_bit(input hsr_chan_t vec, input logic [1:0] cls, input logic [4:0] ch);
      if (cls == HSR_SRC_NONE) begin
         src_bit = 1'b0;
      end else begin
         src_bit = vec[cls][ch];
      end
   endfunction

   // Lowest set index of an event vector
   function automatic logic [4:0] first_set(input logic [NENT-1:0] v);
      first_set = 5'h00;
      for (int i = NENT - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 5'(i);
         end
      end
   endfunction

   // Register storage
   logic [`HSR_CFG_WIDTH-1:0] cfg_mem  [NENT];
   logic [31:0]               comp_mem [NENT];
   logic [31:0]               comp_act [NENT];
   logic [31:0]               time_mem [NENT];
   logic [1:0]                resp_sel;
   logic [NENT-1:0]           valid_flag;
   logic [NENT-1:0]           status;
   logic [NENT-1:0]           int_stat;
   logic [NENT-1:0]           int_mask;

   // Microsecond time base
   logic [15:0]               us_pre;
   logic [31:0]               us_now;
   wire logic                 us_tick = (us_pre == 16'(CYC_PER_US - 1));

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         us_pre <= 16'h0000;
         us_now <= `HSR_RST_WORD;
      end else begin
         us_pre <= us_tick ? 16'h0000 : us_pre + 16'h0001;
         us_now <= us_tick ? us_now + 32'h0000_0001 : us_now;
      end
   end

   // Raw channel levels per class; module channels vanish off the main base
   wire hsr_chan_t raw_lvl;
   wire logic      ext_ok = ext_main_base_i;
   assign raw_lvl[HSR_SRC_BUILTIN] = 32'({builtin_digital_input_i});
   assign raw_lvl[HSR_SRC_PROX]    = ext_ok ? 32'({proximity_change_input_i}) : 32'h0;
   assign raw_lvl[HSR_SRC_TRACK]   = ext_ok ? 32'({tracking_enable_input_i}) : 32'h0;

   // Sampling grid period per class sets the detection accuracy
   wire logic [15:0] resp_cyc = (resp_sel == HSR_RESP_0P4) ? 16'(ACC_R04_CYC) :
                                (resp_sel == HSR_RESP_0P6) ? 16'(ACC_R06_CYC) :
                                16'(ACC_R10_CYC);

   wire hsr_chan_t  cur_lvl;
   wire hsr_chan_t  prev_lvl;
   wire hsr_chan_t  cls_stamp;
   wire logic [2:0] cls_fresh;

   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_class
         logic [15:0] cnt;
         logic [31:0] cur_q;
         logic [31:0] prev_q;
         logic [31:0] stamp_q;
         logic        fresh_q;
         wire  logic [15:0] period = (k == 0) ? 16'(ACC_BI_CYC) : resp_cyc;
         wire  logic        tick   = (cnt >= period - 16'h0001);

         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               cnt     <= 16'h0000;
               cur_q   <= `HSR_RST_WORD;
               prev_q  <= `HSR_RST_WORD;
               stamp_q <= `HSR_RST_WORD;
               fresh_q <= 1'b0;
            end else begin
               cnt     <= tick ? 16'h0000 : cnt + 16'h0001;
               fresh_q <= tick;
               if (tick) begin
                  prev_q  <= cur_q;
                  cur_q   <= raw_lvl[k];
                  stamp_q <= us_now;
               end
            end
         end

         assign cur_lvl[k]   = cur_q;
         assign prev_lvl[k]  = prev_q;
         assign cls_stamp[k] = stamp_q;
         assign cls_fresh[k] = fresh_q;
      end
   endgenerate

   // Per-entry detection
   logic [NENT-1:0] accept;
   logic [NENT-1:0] drop_clear;
   logic [NENT-1:0] lvl_now;
   logic [31:0]     eff_time [NENT];

   genvar n;
   generate
      for (n = 0; n < NENT; n++) begin : g_entry
         wire logic [1:0] cls      = cfg_mem[n][`HSR_CFG_SRC_MSB:`HSR_CFG_SRC_LSB];
         wire logic [4:0] ch       = cfg_mem[n][`HSR_CFG_CH_MSB:`HSR_CFG_CH_LSB];
         wire logic       falling  = cfg_mem[n][`HSR_CFG_FALLING];
         wire logic       vused    = cfg_mem[n][`HSR_CFG_VALID_USED];
         wire logic       en       = cfg_mem[n][`HSR_CFG_ENABLE];
         wire logic       lvl      = src_bit(cur_lvl, cls, ch);
         wire logic       plvl     = src_bit(prev_lvl, cls, ch);
         wire logic       fresh    = en && (cls != HSR_SRC_NONE) && cls_fresh[cls];
         wire logic       edge_hit = fresh && (falling ? (plvl && !lvl) : (!plvl && lvl));
         wire logic       need     = sync_control_active_i[n] && encoder_axis_control_request_i[n];
         // Flag read in the very cycle the edge is seen
         wire logic       vnow     = !vused || valid_flag[n];
         wire logic [31:0] stamp   = (cls == HSR_SRC_NONE) ? 32'h0 : cls_stamp[cls];

         assign lvl_now[n]    = lvl;
         assign accept[n]     = edge_hit && vnow && need;
         assign drop_clear[n] = edge_hit && !need && vused;
         // Wraps with the time base; shift by signed compensation
         assign eff_time[n]   = stamp + sat_comp(comp_act[n]);
      end
   endgenerate

   // APB decode
   wire logic        acc      = psel_i && penable_i;
   wire logic        setup_rd = psel_i && !penable_i && !pwrite_i;
   wire logic        aligned  = (paddr_i[1:0] == 2'b00);
   wire logic        in_ent   = aligned && (paddr_i[11:9] == `HSR_ENTRY_REGION)
                                && (32'(paddr_i[8:4]) < NENT) && (paddr_i[3:2] != 2'h3);
   wire logic [4:0]  ent_idx  = paddr_i[8:4];
   wire logic        hit_ctrl = aligned && (paddr_i == `HSR_OFS_CTRL);
   wire logic        hit_val  = aligned && (paddr_i == `HSR_OFS_VALID);
   wire logic        hit_sts  = aligned && (paddr_i == `HSR_OFS_STATUS);
   wire logic        hit_ist  = aligned && (paddr_i == `HSR_OFS_INT_STAT);
   wire logic        hit_imk  = aligned && (paddr_i == `HSR_OFS_INT_MASK);
   wire logic        hit_tst  = aligned && (paddr_i == `HSR_OFS_TSTAMP);
   wire logic        mapped   = hit_ctrl || hit_val || hit_sts || hit_ist || hit_imk || hit_tst || in_ent;
   wire logic        wr       = acc && pwrite_i && mapped;
   wire logic        wr_ent   = wr && in_ent;
   wire logic [1:0]  ent_reg  = paddr_i[3:2];

   wire logic [31:0] ent_rd   = (ent_reg == `HSR_ENT_CFG)  ? 32'(cfg_mem[ent_idx]) :
                                (ent_reg == `HSR_ENT_COMP) ? comp_mem[ent_idx] :
                                time_mem[ent_idx];
   wire logic [31:0] rd_mux   = hit_ctrl ? 32'(resp_sel) :
                                hit_val  ? 32'(valid_flag) :
                                hit_sts  ? 32'(status) :
                                hit_ist  ? 32'(int_stat) :
                                hit_imk  ? 32'(int_mask) :
                                hit_tst  ? us_now :
                                in_ent   ? ent_rd : 32'h0000_0000;

   assign pready_o  = 1'b1;
   assign pslverr_o = acc && !mapped;

   // Read data captured in the setup cycle, stable through the access cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prdata_o <= `HSR_RST_WORD;
      end else if (setup_rd) begin
         prdata_o <= rd_mux;
      end
   end

   // Global registers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         resp_sel   <= `HSR_RST_RESP;
         int_mask   <= NENT'(`HSR_RST_WORD);
         valid_flag <= NENT'(`HSR_RST_WORD);
         int_stat   <= NENT'(`HSR_RST_WORD);
         status     <= NENT'(`HSR_RST_WORD);
      end else begin
         if (wr && hit_ctrl) begin
            resp_sel <= pwdata_i[1:0];
         end
         if (wr && hit_imk) begin
            int_mask <= pwdata_i[NENT-1:0];
         end
         // Software re-arm wins over a same-cycle hardware clear
         if (wr && hit_val) begin
            valid_flag <= pwdata_i[NENT-1:0];
         end else begin
            valid_flag <= valid_flag & ~drop_clear;
         end
         // New events win over the write-one clear
         int_stat <= (int_stat & ~((wr && hit_ist) ? pwdata_i[NENT-1:0] : NENT'(0))) | accept;
         if (op_cycle_i) begin
            status <= lvl_now;
         end
      end
   end

   // Entry arrays
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < NENT; i++) begin
            cfg_mem[i]  <= `HSR_RST_CFG;
            comp_mem[i] <= `HSR_RST_WORD;
            comp_act[i] <= `HSR_RST_WORD;
            time_mem[i] <= `HSR_RST_WORD;
         end
      end else begin
         if (wr_ent && (ent_reg == `HSR_ENT_CFG)) begin
            cfg_mem[ent_idx] <= pwdata_i[`HSR_CFG_WIDTH-1:0];
         end
         if (wr_ent && (ent_reg == `HSR_ENT_COMP)) begin
            comp_mem[ent_idx] <= pwdata_i;
         end
         for (int i = 0; i < NENT; i++) begin
            if (op_cycle_i) begin
               comp_act[i] <= comp_mem[i];
            end
            if (accept[i]) begin
               time_mem[i] <= eff_time[i];
            end
         end
      end
   end

   // Event outputs, lowest entry reported when several fire together
   wire logic [4:0] first = first_set(accept);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         event_o        <= NENT'(`HSR_RST_WORD);
         event_strobe_o <= 1'b0;
         event_entry_o  <= 5'h00;
         event_action_o <= 3'h0;
         event_time_o   <= `HSR_RST_WORD;
      end else begin
         event_o        <= accept;
         event_strobe_o <= |accept;
         if (|accept) begin
            event_entry_o  <= first;
            event_action_o <= cfg_mem[first][`HSR_CFG_ACT_MSB:`HSR_CFG_ACT_LSB];
            event_time_o   <= eff_time[first];
         end
      end
   end

   assign irq_o = |(int_stat & int_mask);

endmodule // hsr_request_unit

// ==== test/hsr_request_unit_assertions.sv ====
// Purpose: port-level checks of the request unit
// Assumes: one clock domain, synchronous active-high reset
// Notes:   event outputs describe the lowest accepted entry
module hsr_request_unit_checker #(
   parameter int NENT = 32
) (
   input wire logic            clock_i,
   input wire logic            rst_i,
   input wire logic [11:0]     paddr_i,
   input wire logic            psel_i,
   input wire logic            penable_i,
   input wire logic            pwrite_i,
   input wire logic [31:0]     prdata_o,
   input wire logic            pready_o,
   input wire logic            pslverr_o,
   input wire logic [NENT-1:0] sync_control_active_i,
   input wire logic [NENT-1:0] encoder_axis_control_request_i,
   input wire logic [NENT-1:0] event_o,
   input wire logic            event_strobe_o,
   input wire logic [4:0]      event_entry_o,
   input wire logic [2:0]      event_action_o,
   input wire logic [31:0]     event_time_o,
   input wire logic            irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   wire logic [NENT-1:0] need = sync_control_active_i & encoder_axis_control_request_i;
   zero_wait_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("access phase without ready");
   err_access_a: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("error outside access phase");
   err_unaligned_a: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("unaligned access accepted");
   err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read returned data");
   strobe_any_a: assert property (event_strobe_o == (event_o != '0))
      else $error("strobe disagrees with event vector");
   event_pulse_a: assert property ((event_o & $past(event_o)) == '0)
      else $error("event longer than one cycle");
   lowest_entry_a: assert property (event_strobe_o |-> event_o[event_entry_o]
      && (event_o & ((NENT'(1) << event_entry_o) - NENT'(1))) == '0 && event_action_o <= 3'h4)
      else $error("event fields not of lowest entry");
   event_hold_a: assert property (!event_strobe_o |-> $stable(event_time_o)
      && $stable(event_entry_o) && $stable(event_action_o))
      else $error("event fields changed without strobe");
   need_gate_a: assert property ((event_o & ~$past(need)) == '0)
      else $error("event while detection not needed");
   irq_cause_a: assert property ($rose(irq_o) |-> event_strobe_o || $past(psel_i && penable_i && pwrite_i))
      else $error("interrupt rose without cause");
   irq_clear_a: assert property ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
      else $error("interrupt fell without write");
endmodule // hsr_request_unit_checker

bind hsr_request_unit hsr_request_unit_checker #(.NENT(NENT)) hsr_request_unit_checker_inst (
   .clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .sync_control_active_i(sync_control_active_i),
   .encoder_axis_control_request_i(encoder_axis_control_request_i), .event_o(event_o),
   .event_strobe_o(event_strobe_o), .event_entry_o(event_entry_o), .event_action_o(event_action_o),
   .event_time_o(event_time_o), .irq_o(irq_o));

// ==== test/hsr_sensor_model.sv ====
// Purpose: sensor levels feeding the request inputs
// Assumes: bench calls toggle to flip one channel
// Notes:   changes are spaced so every sampling grid sees each level
module hsr_sensor_model #(
   parameter int HOLD = 40
) (
   input  wire logic       clock_i,
   output logic      [3:0] bi_o,
   output logic      [7:0] prox_o,
   output logic      [7:0] trk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int now  = 0;
   int last = 0;
   initial begin
      bi_o   = 4'h0;
      prox_o = 8'h00;
      trk_o  = 8'h00;
   end
   always @(posedge clock_i) begin
      now <= now + 1;
   end
   // A faster sensor would put two edges in one sampling period
   task automatic toggle(input int src, input int ch);
      @(posedge clock_i);
      while (now - last < HOLD) @(posedge clock_i);
      last = now;
      case (src)
         0: bi_o[ch]   <= ~bi_o[ch];
         1: prox_o[ch] <= ~prox_o[ch];
         default: trk_o[ch] <= ~trk_o[ch];
      endcase
   endtask
endmodule // hsr_sensor_model

// ==== test/test_high_speed_input_request_unit.sv ====
// Purpose: self-checking bench of the request unit
// Assumes: shortened sampling grids, two cycles per microsecond
// Notes:   operation cycle pulse every 20 clocks
module test_high_speed_input_request_unit;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIM = 200;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        op_cycle = 1'b0;
   logic        ext_main = 1'b1;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] sync_act = 32'hFFFF_FFFF;
   logic [31:0] axis_req = 32'hFFFF_FFFF;
   logic [31:0] prdata, ev, ev_time, rd, t0, tb0;
   logic        pready, pslverr, strobe, irq, err;
   logic [3:0]  bi;
   logic [7:0]  prox, trk;
   logic [4:0]  ev_entry;
   logic [2:0]  ev_act;
   logic [31:0] cv [4] = '{32'h0, 32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFD};
   logic [31:0] xd [4] = '{32'h0, 32'h004C_4B40, 32'hFFB3_B4C0, 32'hFFFF_FFFD};
   int          en [4] = '{0, 1, 2, 31};
   int          acc [3] = '{12, 14, 16};
   int          num_errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          lat;

   hsr_request_unit #(.ACC_BI_CYC(10), .ACC_R04_CYC(12), .ACC_R06_CYC(14), .ACC_R10_CYC(16), .CYC_PER_US(2))
   hsr_request_unit_inst (.clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .builtin_digital_input_i(bi), .proximity_change_input_i(prox),
      .tracking_enable_input_i(trk), .ext_main_base_i(ext_main), .op_cycle_i(op_cycle),
      .sync_control_active_i(sync_act), .encoder_axis_control_request_i(axis_req), .event_o(ev),
      .event_strobe_o(strobe), .event_entry_o(ev_entry), .event_action_o(ev_act),
      .event_time_o(ev_time), .irq_o(irq));
   hsr_sensor_model hsr_sensor_model_inst (.clock_i(clock_i), .bi_o(bi), .prox_o(prox), .trk_o(trk));

   always #25 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      op_cycle <= (cyc % 20) == 19;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         conclude();
      end
   end

   task automatic conclude;
      $display("errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) @(posedge clock_i);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk({31'h0, err}, 32'h0);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic wait_ev;
      lat = 0;
      do begin
         @(posedge clock_i);
         lat++;
      end while (strobe !== 1'b1 && lat < LIM);
   endtask
   function automatic logic [11:0] ent(input int n, input int r);
      return 12'(32'h400 + n * 16 + r * 4);
   endfunction

   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rdc(12'(i * 4), 32'hFFFF_FFFF, 32'h0);
      end
      rdc(ent(31, 0), 32'hFFFF_FFFF, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 12'h006, 32'h1);
      chk({31'h0, err}, 32'h1);
      // Every action, alternating edge direction, no valid flag
      for (int a = 0; a < 5; a++) begin
         wr(ent(0, 0), 32'(32'h1000 | (a << 9) | ((a % 2) << 7)));
         apb(1'b0, 12'h014, 32'h0);
         t0 = rd;
         hsr_sensor_model_inst.toggle(0, 0);
         wait_ev;
         chk(ev, 32'h1);
         // Built-in grid of 10 cycles, plus edge and output stages
         chk({31'h0, lat <= 14}, 32'h1);
         chk({27'h0, ev_entry}, 32'h0);
         chk({29'h0, ev_act}, 32'(a));
         tb0 = ev_time;
         apb(1'b0, 12'h014, 32'h0);
         chk({31'h0, tb0 >= t0 && tb0 <= rd}, 32'h1);
      end
      repeat (25) @(posedge clock_i);
      rdc(12'h008, 32'h1, 32'h1);
      rdc(12'h00C, 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(12'h010, 32'h1);
      @(posedge clock_i);
      chk({31'h0, irq}, 32'h1);
      wr(12'h00C, 32'h1);
      @(posedge clock_i);
      chk({31'h0, irq}, 32'h0);
      rdc(12'h00C, 32'h1, 32'h0);
      // Saturated and signed compensation on four entries of one edge
      for (int i = 0; i < 4; i++) begin
         wr(ent(en[i], 0), 32'h1004);
         wr(ent(en[i], 1), cv[i]);
      end
      repeat (45) @(posedge clock_i);
      hsr_sensor_model_inst.toggle(0, 1);
      wait_ev;
      chk(ev, 32'h8000_0007);
      apb(1'b0, ent(0, 2), 32'h0);
      tb0 = rd;
      for (int i = 1; i < 4; i++) begin
         apb(1'b0, ent(en[i], 2), 32'h0);
         chk(rd - tb0, xd[i]);
      end
      // Valid flag off, then need off, then rearmed
      wr(ent(0, 0), 32'h1108);
      for (int i = 1; i < 4; i++) begin
         wr(ent(en[i], 0), 32'h0);
      end
      wr(12'h004, 32'h0);
      hsr_sensor_model_inst.toggle(0, 2);
      wait_ev;
      chk(32'(lat), 32'(LIM));
      repeat (25) @(posedge clock_i);
      rdc(12'h008, 32'h1, 32'h1);
      hsr_sensor_model_inst.toggle(0, 2);
      wr(12'h004, 32'h1);
      sync_act <= 32'hFFFF_FFFE;
      hsr_sensor_model_inst.toggle(0, 2);
      wait_ev;
      chk(32'(lat), 32'(LIM));
      rdc(12'h004, 32'h1, 32'h0);
      sync_act <= 32'hFFFF_FFFF;
      wr(12'h004, 32'h1);
      hsr_sensor_model_inst.toggle(0, 2);
      hsr_sensor_model_inst.toggle(0, 2);
      wait_ev;
      chk(ev, 32'h1);
      // Module channels: hidden off the main base, grid by response time
      wr(ent(0, 0), 32'h1002);
      ext_main <= 1'b0;
      hsr_sensor_model_inst.toggle(2, 0);
      wait_ev;
      chk(32'(lat), 32'(LIM));
      hsr_sensor_model_inst.toggle(2, 0);
      ext_main <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         wr(12'h000, 32'(r));
         hsr_sensor_model_inst.toggle(2, 0);
         wait_ev;
         chk({31'h0, lat <= acc[r] + 4}, 32'h1);
         hsr_sensor_model_inst.toggle(2, 0);
      end
      wr(ent(0, 0), 32'h1001);
      hsr_sensor_model_inst.toggle(1, 0);
      wait_ev;
      chk(ev, 32'h1);
      conclude();
   end
endmodule // test_high_speed_input_request_unit
